// file: hw/rap_pkg.sv
// Purpose: constants and types for the region access protection unit
// Assumes: APB slave, 32-bit data, eight regions
// Notes: all offsets are byte addresses
//
// What this block does
// - region sizes are powers of two, 32 bytes to 4 gigabytes, as a size code.
// - a set exec_denied bit makes instruction fetches into the region violate.
// - a permission code gives privileged and user read/write rights separately.
// - each region splits into eight equal sub-regions indexed from the base.
// - sub-region disables only act for regions of 256 bytes or more.
// - an address in a disabled sub-region does not match that region.
// - a region with its enable bit clear takes no part in checking.
// - clearing the enable bit keeps the base; the same attribute write reloads all other attribute fields.
// - an access breaking an enabled region's permissions raises a fault.
// - a readable register holds the number of regions implemented.
// - reading a region returns base and attribute fields as written, enable included, unused attribute bits as zero, and size codes below 4 as 4.
// - at most eight regions, each with its own full set of settings.
// - with the unit disabled no faults are raised and the default map applies.
// - an option lets privileged accesses fall to the default map when nothing hits.
// - an option keeps checking active in hard fault and nmi handlers.
package rap_pkg;
    localparam int rap_regions = 8;
    localparam logic [3:0] rap_region_count = 4'h8;
    // apb byte offsets
    localparam logic [11:0] rap_off_ctrl = 12'h000;
    localparam logic [11:0] rap_off_count = 12'h004;
    localparam logic [11:0] rap_off_status = 12'h008;
    localparam logic [11:0] rap_off_fault_addr = 12'h00c;
    localparam logic [11:0] rap_off_region_base = 12'h100;
    // each region: base word then attribute word
    localparam int rap_region_stride_sh = 3;
    localparam int rap_attr_word_bit = 2;
    // ctrl fields
    localparam int rap_ctrl_enable = 0;
    localparam int rap_ctrl_check_in_fault_handlers = 1;
    localparam int rap_ctrl_privileged_background_map = 2;
    // status fields
    localparam int rap_status_fault_bit = 0;
    // attribute word fields
    localparam int rap_attr_region_on = 0;
    localparam int rap_attr_size_lo = 1;
    localparam int rap_attr_size_w = 5;
    localparam int rap_attr_sub_lo = 8;
    localparam int rap_attr_perm_lo = 24;
    localparam int rap_attr_perm_w = 3;
    localparam int rap_attr_exec_denied = 28;
    localparam logic [31:0] rap_attr_mask = 32'h1700ff3f;
    // size code: region bytes = 2 ** (code + 1)
    localparam logic [4:0] rap_size_min_code = 5'h04;
    localparam logic [4:0] rap_size_max_code = 5'h1f;
    localparam logic [4:0] rap_size_sub_code = 5'h07;
    // permission codes
    localparam logic [2:0] perm_none_none = 3'h0;
    localparam logic [2:0] perm_priv_rw_user_none = 3'h1;
    localparam logic [2:0] perm_priv_rw_user_ro = 3'h2;
    localparam logic [2:0] perm_priv_rw_user_rw = 3'h3;
    localparam logic [2:0] perm_priv_ro_user_none = 3'h5;
    localparam logic [2:0] perm_priv_ro_user_ro = 3'h6;

    typedef struct packed {
        logic [31:0] base;
        logic exec_denied;
        logic [2:0] perm;
        logic [7:0] subregion_off_bit;
        logic [4:0] region_size_code;
        logic region_on;
    } rap_region_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic fetch;
        logic privileged;
        logic in_fault_handler;
    } rap_access_t;

    typedef struct packed {
        logic hit;
        logic [2:0] index;
    } rap_match_t;
endpackage

// file: hw/rap_region_match.sv
// Purpose: address match of one protection region
// Assumes: base aligned to size by software
// Notes: purely combinational
`timescale 1ns/1ns
`default_nettype none
module rap_region_match
(
    // region and address
    input wire rap_pkg::rap_region_t region,
    input wire logic [31:0] addr,
    // result
    output logic hit
);
    import rap_pkg::*;
    logic [32:0] size_mask;
    logic [2:0] sub_index;
    logic in_range;
    always_comb
    begin
        // mask of offset bits inside the region
        size_mask = (33'h1 << ({28'h0, region.region_size_code} + 33'h1)) - 33'h1;
        in_range = ((addr ^ region.base) & ~size_mask[31:0]) == 32'h0;
        sub_index = 3'(({1'b0, addr} >> ({28'h0, region.region_size_code} - 33'h2)) & 33'h7);
        hit = region.region_on && in_range;
        if (region.region_size_code >= rap_size_sub_code && region.subregion_off_bit[sub_index])
        begin
            hit = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hw/rap_top.sv
// Purpose: region access protection unit with apb register file
// Assumes: core issues one access per cycle on the check port
// Notes: fault is a one-cycle pulse one cycle after the access
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rap_top
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // access check
    input wire rap_pkg::rap_access_t access,
    output logic fault,
    output logic default_map_used
);
    import rap_pkg::*;

    rap_region_t regions [rap_regions];
    logic [rap_regions-1:0] hits;
    logic unit_enable;
    logic check_in_fault_handlers;
    logic privileged_background_map;
    logic fault_sticky;
    logic [31:0] fault_addr;
    logic next_fault;
    logic next_default;
    rap_match_t best;
    logic [31:0] next_rdata;
    logic addr_ok;
    logic wr_en;

    typedef enum logic [1:0] {st_idle = 2'b01, st_access = 2'b10} rap_state_t;
    rap_state_t state;

    function automatic logic [31:0] rap_attr_pack(input rap_region_t r);
        logic [31:0] w;
        w = 32'h0;
        w[rap_attr_region_on] = r.region_on;
        w[rap_attr_size_lo +: rap_attr_size_w] = r.region_size_code;
        w[rap_attr_sub_lo +: 8] = r.subregion_off_bit;
        w[rap_attr_perm_lo +: rap_attr_perm_w] = r.perm;
        w[rap_attr_exec_denied] = r.exec_denied;
        return w;
    endfunction

    function automatic logic rap_is_region(input logic [11:0] a);
        return a >= rap_off_region_base && a < rap_off_region_base + 12'(rap_regions << rap_region_stride_sh);
    endfunction

    function automatic logic [2:0] rap_region_index(input logic [11:0] a);
        logic [11:0] d;
        d = a - rap_off_region_base;
        return d[rap_region_stride_sh +: 3];
    endfunction

    for (genvar g = 0; g < rap_regions; g++)
    begin : gen_match
        rap_region_match u_match
        (
            .region(regions[g]),
            .addr(access.addr),
            .hit(hits[g])
        );
    end

    // apb handshake: one wait-free access phase
    // zero wait states: every readable field is a flop or a constant
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            state <= st_idle;
            pready <= 1'b0;
        end
        else
        begin
            case (state)
                st_idle:
                begin
                    pready <= 1'b0;
                    if (psel && !penable)
                    begin
                        state <= st_access;
                        pready <= 1'b1;
                    end
                end
                st_access:
                begin
                    pready <= 1'b0;
                    state <= st_idle;
                end
                default:
                begin
                    state <= st_idle;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // refused transfers must leave every register untouched
    always_comb
    begin
        wr_en = psel && penable && pready && pwrite && (pstrb == 4'hf) && addr_ok;
    end

    // decode, also used to answer unmapped addresses with pslverr
    always_comb
    begin
        addr_ok = 1'b1;
        next_rdata = 32'h0;
        if (paddr[1:0] != 2'h0)
        begin
            addr_ok = 1'b0;
        end
        else if (paddr == rap_off_ctrl)
        begin
            next_rdata[rap_ctrl_enable] = unit_enable;
            next_rdata[rap_ctrl_check_in_fault_handlers] = check_in_fault_handlers;
            next_rdata[rap_ctrl_privileged_background_map] = privileged_background_map;
        end
        else if (paddr == rap_off_count)
        begin
            next_rdata = {28'h0, rap_region_count};
        end
        else if (paddr == rap_off_status)
        begin
            next_rdata[rap_status_fault_bit] = fault_sticky;
        end
        else if (paddr == rap_off_fault_addr)
        begin
            next_rdata = fault_addr;
        end
        else if (rap_is_region(paddr))
        begin
            if (paddr[rap_attr_word_bit])
            begin
                next_rdata = rap_attr_pack(regions[rap_region_index(paddr)]);
            end
            else
            begin
                next_rdata = regions[rap_region_index(paddr)].base;
            end
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // read data and error, registered in the setup cycle
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (state == st_idle && psel && !penable)
        begin
            prdata <= pwrite ? 32'h0 : next_rdata;
            // partial writes refused: fields would tear
            pslverr <= !addr_ok || (pwrite && pstrb != 4'hf);
        end
        else
        begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
    end

    // global control
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            unit_enable <= 1'b0;
            check_in_fault_handlers <= 1'b0;
            privileged_background_map <= 1'b0;
        end
        else if (wr_en && paddr == rap_off_ctrl)
        begin
            unit_enable <= pwdata[rap_ctrl_enable];
            check_in_fault_handlers <= pwdata[rap_ctrl_check_in_fault_handlers];
            privileged_background_map <= pwdata[rap_ctrl_privileged_background_map];
        end
    end

    // region storage; each word written alone
    // regions come out of reset off with size code 4, so none can hit until written
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < rap_regions; i++)
            begin
                regions[i] <= '0;
                regions[i].region_size_code <= rap_size_min_code;
            end
        end
        else if (wr_en && rap_is_region(paddr))
        begin
            if (paddr[rap_attr_word_bit])
            begin
                // the enable bit is loaded in one write along with all other attribute fields
                regions[rap_region_index(paddr)].region_on <= pwdata[rap_attr_region_on];
                regions[rap_region_index(paddr)].region_size_code <=
                    (pwdata[rap_attr_size_lo +: rap_attr_size_w] < rap_size_min_code) ?
                    rap_size_min_code : pwdata[rap_attr_size_lo +: rap_attr_size_w];
                regions[rap_region_index(paddr)].subregion_off_bit <= pwdata[rap_attr_sub_lo +: 8];
                regions[rap_region_index(paddr)].perm <= pwdata[rap_attr_perm_lo +: rap_attr_perm_w];
                regions[rap_region_index(paddr)].exec_denied <= pwdata[rap_attr_exec_denied];
            end
            else
            begin
                regions[rap_region_index(paddr)].base <= pwdata;
            end
        end
    end

    // highest numbered hit wins
    always_comb
    begin
        best = '0;
        for (int i = 0; i < rap_regions; i++)
        begin
            if (hits[i])
            begin
                best.hit = 1'b1;
                best.index = 3'(i);
            end
        end
    end

    // permission evaluation
    always_comb
    begin
        rap_region_t r;
        logic rd_ok;
        logic wr_ok;
        r = regions[best.index];
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        next_fault = 1'b0;
        next_default = 1'b0;
        // codes 4 and 7 are left unused and deny every access
        case (r.perm)
            perm_priv_rw_user_none:
            begin
                rd_ok = access.privileged;
                wr_ok = access.privileged;
            end
            perm_priv_rw_user_ro:
            begin
                rd_ok = 1'b1;
                wr_ok = access.privileged;
            end
            perm_priv_rw_user_rw:
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
            end
            perm_priv_ro_user_none:
            begin
                rd_ok = access.privileged;
            end
            perm_priv_ro_user_ro:
            begin
                rd_ok = 1'b1;
            end
            default:
            begin
                rd_ok = 1'b0;
            end
        endcase
        if (!access.valid)
        begin
            next_fault = 1'b0;
        end
        else if (!unit_enable || (access.in_fault_handler && !check_in_fault_handlers))
        begin
            next_default = 1'b1;
        end
        else if (!best.hit)
        begin
            if (access.privileged && privileged_background_map)
            begin
                next_default = 1'b1;
            end
            else
            begin
                next_fault = 1'b1;
            end
        end
        else
        begin
            // a fetch must also pass the read check
            next_fault = (access.fetch && r.exec_denied) || !(access.write ? wr_ok : rd_ok);
        end
    end

    // fault_addr keeps only the newest violation
    // fault pulse and capture; set wins over clear
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            fault <= 1'b0;
            default_map_used <= 1'b0;
            fault_sticky <= 1'b0;
            fault_addr <= 32'h0;
        end
        else
        begin
            fault <= next_fault;
            default_map_used <= next_default;
            if (next_fault)
            begin
                fault_sticky <= 1'b1;
                fault_addr <= access.addr;
            end
            else if (wr_en && paddr == rap_off_status && pwdata[rap_status_fault_bit])
            begin
                fault_sticky <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/rap_checker_sva.sv
// Purpose: port checks for the protection unit
// Assumes: one clock, sync active-low reset
// Notes: unit enable is shadowed from accepted apb writes
`timescale 1ns/1ns
`default_nettype none
module rap_checker_sva
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // access check
    input wire rap_pkg::rap_access_t access,
    input wire logic fault,
    input wire logic default_map_used
);
    import rap_pkg::*;
    logic unit_on;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // refused writes must not move the shadow
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            unit_on <= 1'h0;
        else if (pready && pwrite && !pslverr && paddr == rap_off_ctrl)
            unit_on <= pwdata[rap_ctrl_enable];
    end
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    chk_count_value: assert property (pready && !pwrite && paddr == rap_off_count |-> prdata == 32'h8)
        else $error("region count wrong");
    chk_misaligned_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    chk_off_no_fault: assert property (access.valid && !unit_on |=> !fault && default_map_used)
        else $error("disabled unit checked an access");
    chk_idle_quiet: assert property (!access.valid |=> !fault && !default_map_used)
        else $error("event without access");
    chk_fault_excl: assert property (fault |-> !default_map_used)
        else $error("fault and default map together");
    chk_user_no_map: assert property (access.valid && unit_on && !access.privileged
        && !access.in_fault_handler |=> !default_map_used)
        else $error("user access fell to default map");
    cover property (fault);
    cover property (access.valid && unit_on ##1 !fault);
    cover property (pready && pslverr);
endmodule
`default_nettype wire

// file: verif/rap_core_model.sv
// Purpose: behavioural core issuing checked accesses
// Assumes: same clock as the unit, one access per call
// Notes: idle address is inverted so stale values are never trusted
`timescale 1ns/1ns
`default_nettype none
module rap_core_model
(
    // clock
    input wire logic core_clk,
    // access out
    output var rap_pkg::rap_access_t access
);
    import rap_pkg::*;
    initial access = '0;
    task automatic drive(input logic [31:0] a, input logic w, input logic f, input logic p, input logic h);
        @(posedge core_clk);
        access <= '{1'h1, a, w, f, p, h};
        @(posedge core_clk);
        access <= '{1'h0, ~a, 1'h0, 1'h0, 1'h0, 1'h0};
    endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: self-checking bench for the protection unit
// Assumes: apb slave answers within a bounded wait
// Notes: the core model drives the check port
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rap_pkg::*;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rap_access_t access;
    logic fault;
    logic default_map_used;
    logic [31:0] rdata;
    logic rerr;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [2:0] perms [6] = '{perm_none_none, perm_priv_rw_user_none, perm_priv_rw_user_ro,
        perm_priv_rw_user_rw, perm_priv_ro_user_none, perm_priv_ro_user_ro};
    rap_top dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .access(access), .fault(fault), .default_map_used(default_map_used));
    rap_core_model core (.core_clk(core_clk), .access(access));
    initial forever #20 core_clk = ~core_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        while (pready !== 1'h1)
        begin
            @(posedge core_clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'h0, a, 32'h0);
        check(rdata, e);
        check(32'(rerr), 32'(ee));
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
        apb(1'h1, a, d);
        check(32'(rerr), 32'(ee));
    endtask
    task automatic acc(input logic [31:0] a, input logic [3:0] wfph, input logic ef, input logic ed);
        core.drive(a, wfph[3], wfph[2], wfph[1], wfph[0]);
        #1;
        check(32'(fault), 32'(ef));
        check(32'(default_map_used), 32'(ed));
    endtask
    function automatic logic [11:0] rb(int n);
        return rap_off_region_base + 12'(n * 8);
    endfunction
    function automatic logic [31:0] attr(logic on, logic [4:0] sz, logic [7:0] sub, logic [2:0] pm, logic xd);
        return {3'h0, xd, 1'h0, pm, 8'h00, sub, 2'h0, sz, on};
    endfunction
    function automatic logic allowed(logic [2:0] pm, logic pv, logic w);
        case (pm)
            perm_priv_rw_user_none: return pv;
            perm_priv_rw_user_ro: return pv || !w;
            perm_priv_rw_user_rw: return 1'h1;
            perm_priv_ro_user_none: return pv && !w;
            perm_priv_ro_user_ro: return !w;
            default: return 1'h0;
        endcase
    endfunction
    task automatic t_regs();
        rd(rap_off_count, 32'h8, 1'h0);
        rd(rb(7) + 12'h4, 32'h8, 1'h0);
        rd(12'h050, 32'h0, 1'h1);
        pstrb <= 4'h3;
        wr(rap_off_ctrl, 32'h1, 1'h1);
        pstrb <= 4'hf;
        rd(rap_off_ctrl, 32'h0, 1'h0);
        for (int n = 0; n < 8; n++)
        begin
            wr(rb(n), {4'(n), 28'h1234560}, 1'h0);
            wr(rb(n) + 12'h4, ~32'(n), 1'h0);
            rd(rb(n) + 12'h4, ~32'(n) & rap_attr_mask, 1'h0);
            wr(rb(n) + 12'h4, 32'h0, 1'h0);
            rd(rb(n), {4'(n), 28'h1234560}, 1'h0);
        end
        wr(rb(1) + 12'h2, 32'hffffffff, 1'h1);
        rd(rb(1), {4'h1, 28'h1234560}, 1'h0);
        $display("t_regs done");
    endtask
    task automatic t_perm();
        wr(rb(0), 32'h0, 1'h0);
        wr(rb(0) + 12'h4, attr(1'h1, 5'h0e, 8'h00, perm_none_none, 1'h0), 1'h0);
        acc(32'h100, 4'h8, 1'h0, 1'h1);
        wr(rap_off_ctrl, 32'h1, 1'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(rb(0) + 12'h4, attr(1'h1, 5'h0e, 8'h00, perms[i], 1'h0), 1'h0);
            for (int k = 0; k < 4; k++)
                acc(32'h100, {k[1], 1'h0, k[0], 1'h0}, !allowed(perms[i], k[0], k[1]), 1'h0);
        end
        wr(rb(0) + 12'h4, attr(1'h1, 5'h0e, 8'h00, perm_priv_ro_user_ro, 1'h1), 1'h0);
        acc(32'h100, 4'h6, 1'h1, 1'h0);
        wr(rb(0) + 12'h4, attr(1'h1, 5'h0e, 8'h00, perm_priv_ro_user_ro, 1'h0), 1'h0);
        acc(32'h100, 4'h6, 1'h0, 1'h0);
        $display("t_perm done");
    endtask
    task automatic t_sub();
        // first programming with the unit off; later rewrites happen with it on
        wr(rap_off_ctrl, 32'h0, 1'h0);
        wr(rb(3), 32'h40000000, 1'h0);
        wr(rb(3) + 12'h4, attr(1'h1, 5'h13, 8'h12, perm_priv_rw_user_none, 1'h1), 1'h0);
        wr(rb(4), 32'h40080000, 1'h0);
        wr(rb(4) + 12'h4, attr(1'h1, 5'h10, 8'h00, perm_priv_rw_user_rw, 1'h1), 1'h0);
        wr(rb(2), 32'h20000000, 1'h0);
        wr(rb(2) + 12'h4, attr(1'h1, 5'h06, 8'hff, perm_priv_rw_user_rw, 1'h1), 1'h0);
        wr(rap_off_ctrl, 32'h1, 1'h0);
        acc(32'h400fff00, 4'h2, 1'h0, 1'h0);
        acc(32'h40020000, 4'h2, 1'h1, 1'h0);
        acc(32'h40060000, 4'h0, 1'h1, 1'h0);
        acc(32'h40080000, 4'h8, 1'h0, 1'h0);
        wr(rb(3) + 12'h4, attr(1'h1, 5'h13, 8'h02, perm_priv_rw_user_none, 1'h1), 1'h0);
        acc(32'h40080000, 4'h8, 1'h0, 1'h0);
        acc(32'h20000070, 4'h8, 1'h0, 1'h0);
        wr(rb(2) + 12'h4, attr(1'h1, 5'h07, 8'h01, perm_priv_rw_user_rw, 1'h1), 1'h0);
        acc(32'h20000010, 4'h8, 1'h1, 1'h0);
        acc(32'h20000020, 4'h8, 1'h0, 1'h0);
        $display("t_sub done");
    endtask
    task automatic t_enable();
        wr(rb(5), 32'h0, 1'h0);
        wr(rb(5) + 12'h4, attr(1'h1, 5'h1f, 8'h00, perm_priv_rw_user_rw, 1'h1), 1'h0);
        acc(32'h90000000, 4'h8, 1'h0, 1'h0);
        wr(rb(5) + 12'h4, attr(1'h0, 5'h1f, 8'h00, perm_priv_rw_user_rw, 1'h1), 1'h0);
        acc(32'h90000000, 4'h8, 1'h1, 1'h0);
        rd(rb(5) + 12'h4, attr(1'h0, 5'h1f, 8'h00, perm_priv_rw_user_rw, 1'h1), 1'h0);
        wr(rb(5) + 12'h4, attr(1'h1, 5'h1f, 8'h00, perm_priv_rw_user_rw, 1'h1), 1'h0);
        acc(32'h90000000, 4'h8, 1'h0, 1'h0);
        wr(rb(5) + 12'h4, 32'h0, 1'h0);
        $display("t_enable done");
    endtask
    task automatic t_modes();
        acc(32'hc0000000, 4'h2, 1'h1, 1'h0);
        wr(rap_off_ctrl, 32'h5, 1'h0);
        acc(32'hc0000000, 4'h2, 1'h0, 1'h1);
        acc(32'hc0000000, 4'h0, 1'h1, 1'h0);
        wr(rap_off_ctrl, 32'h1, 1'h0);
        acc(32'hc0000000, 4'h1, 1'h0, 1'h1);
        wr(rap_off_ctrl, 32'h3, 1'h0);
        acc(32'hc0000000, 4'h1, 1'h1, 1'h0);
        rd(rap_off_status, 32'h1, 1'h0);
        rd(rap_off_fault_addr, 32'hc0000000, 1'h0);
        wr(rap_off_status, 32'h1, 1'h0);
        rd(rap_off_status, 32'h0, 1'h0);
        $display("t_modes done");
    endtask
    task automatic t_reset();
        @(posedge core_clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'h1;
        rd(rap_off_ctrl, 32'h0, 1'h0);
        rd(rb(3) + 12'h4, 32'h8, 1'h0);
        acc(32'h100, 4'h8, 1'h0, 1'h1);
        $display("t_reset done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // a hung handshake must still end in the verdict
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'h1;
        t_regs();
        t_perm();
        t_sub();
        t_enable();
        t_modes();
        t_reset();
        summarize();
    end
endmodule
bind rap_top rap_checker_sva chk (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .access(access), .fault(fault), .default_map_used(default_map_used));
`default_nettype wire
